//--- hw/mgpio_bank.sv
// storage of one bank control word with byte-lane writes
`timescale 1ns/1ps
`include "mgpio_consts.svh"
module mgpio_bank
	import mgpio_pkg::*;
#(
	parameter bit HAS_SF = 1'b1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// write port, one pulse per accepted write
	input wire logic wr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] be_i,
	// stored control word
	output mgpio_ctrl_type ctrl_o
);
	logic [31:0] word_q; // stored word
	logic [31:0] word_d; // next word

	// merge enabled byte lanes
	always_comb begin
		word_d = word_q;
		for (int l = 0; l < `MGPIO_LANES; l++) begin
			if (wr_i && be_i[l]) begin
				word_d[l*8 +: 8] = wdata_i[l*8 +: 8];
			end
		end
		// bank without special function keeps that lane at zero
		if (!HAS_SF) begin
			word_d[`MGPIO_SF_LSB +: 8] = 8'h00;
		end
	end

	// register, clears to all-input on reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			word_q <= `MGPIO_CTRL_RST;
		end else begin
			word_q <= word_d;
		end
	end

	assign ctrl_o = mgpio_ctrl_type'(word_q);
endmodule

//--- hw/mgpio_top.sv
// sixteen-line gpio port in two banks behind an avalon-mm slave
// Behaviour
// - sixteen lines, two bank registers of eight
// - four bits per line, special bit bank C
// - all control bits zero gives gpio input
// - direction one alone gives gpio output
// - data reads pin level, write sets output
// - bank A bits 7,3 carry serial tx,rx
// - bank A 6,5,2,1,0 carry modem lines
// - bank C bit 6 green indicator, low lit
// - bank C bit 5 spare host line
`timescale 1ns/1ps
`include "mgpio_consts.svh"
module mgpio_top
	import mgpio_pkg::*;
#(
	parameter int BANK_LINES = `MGPIO_BANK_LINES,
	parameter int SYNC_STAGES = `MGPIO_SYNC_STAGES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// avalon-mm slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// bank A pins
	input wire logic [7:0] pin_a_i,
	output logic [7:0] pin_a_o,
	output logic [7:0] pin_a_oe_o,
	// bank C pins
	input wire logic [7:0] pin_c_i,
	output logic [7:0] pin_c_o,
	output logic [7:0] pin_c_oe_o,
	// serial unit, outgoing functions
	input wire logic ser_txd_i,
	input wire logic ser_dtr_i,
	input wire logic ser_rts_i,
	// serial unit, incoming functions
	output logic ser_rxd_o,
	output logic ser_dsr_o,
	output logic ser_cts_o,
	output logic ser_dcd_o,
	// bank C alternate functions
	input wire logic [7:0] alt_c_i,
	output logic [7:0] alt_c_o,
	// board level status
	output logic led_green_on_o,
	output logic spare_line_level_o
);

	// elaboration checks
	// the register lanes hold exactly eight lines each
	if (BANK_LINES != 8) begin : g_bad_lines
		$error("mgpio_top: BANK_LINES must be 8");
	end
	// fewer than two stages would expose metastability
	if (SYNC_STAGES < 2) begin : g_bad_sync
		$error("mgpio_top: SYNC_STAGES must be at least 2");
	end

	// address decode, used by write and read paths
	// returns one-hot {bank C, bank A}, zero if unmapped
	function automatic logic [1:0] bank_sel(input logic [3:0] addr);
		logic [1:0] sel;
		sel = 2'b00;
		// low two bits ignored, words are aligned
		if ({addr[3:2], 2'b00} == `MGPIO_BANK_A_OFS) begin
			sel = 2'b01;
		end else if ({addr[3:2], 2'b00} == `MGPIO_BANK_C_OFS) begin
			sel = 2'b10;
		end
		return sel;
	endfunction

	// bus request bundle
	mgpio_req_type req;
	assign req.address = avs_address_i;
	assign req.read = avs_read_i;
	assign req.write = avs_write_i;
	assign req.writedata = avs_writedata_i;
	assign req.byteenable = avs_byteenable_i;

	// bus slave state
	logic ack_q; // answer phase of a request
	logic ack_d;
	logic [31:0] rdata_q; // captured read word
	logic [31:0] rdata_d;
	logic req_any; // read or write pending
	logic wr_fire; // write takes effect now
	logic [1:0] wr_sel; // target of a write
	logic [1:0] rd_sel; // target of a read

	// control words of both banks
	mgpio_ctrl_type ctrl_a;
	mgpio_ctrl_type ctrl_c;

	// synchronised pin levels
	logic [7:0] sync_a_q [SYNC_STAGES]; // stage 0 read only by stage 1
	logic [7:0] sync_a_d [SYNC_STAGES];
	logic [7:0] sync_c_q [SYNC_STAGES];
	logic [7:0] sync_c_d [SYNC_STAGES];
	logic [7:0] lvl_a; // settled bank A level
	logic [7:0] lvl_c; // settled bank C level

	// pin drive registers
	mgpio_drive_type drv_a_q;
	mgpio_drive_type drv_a_d;
	mgpio_drive_type drv_c_q;
	mgpio_drive_type drv_c_d;

	// per-line alternate function sources
	logic [7:0] alt_out_a; // serial outputs on bank A lines
	logic [7:0] gp_a; // bank A line in gpio mode
	logic [7:0] gp_c; // bank C line in gpio mode

	// board status registers
	logic led_q;
	logic led_d;
	logic spare_q;
	logic spare_d;

	// handshake
	// every request waits exactly one cycle; the answer edge is
	// the only edge that commits a write, so a held request is
	// never applied twice
	assign req_any = req.read | req.write;
	assign avs_waitrequest_o = req_any & ~ack_q;
	assign wr_fire = req.write & ack_q;
	assign wr_sel = bank_sel(req.address) & {2{wr_fire}};
	assign rd_sel = bank_sel(req.address);

	// bus slave next state
	always_comb begin
		ack_d = req_any & ~ack_q;
		rdata_d = rdata_q;
		// capture in the wait cycle so data stand at the answer edge
		if (req.read && !ack_q) begin
			unique case (rd_sel)
				2'b01: begin
					// bank A has no special-function lane
					rdata_d = {ctrl_a.pin_function_select, ctrl_a.pin_direction,
						8'h00, lvl_a};
				end
				2'b10: begin
					rdata_d = {ctrl_c.pin_function_select, ctrl_c.pin_direction,
						ctrl_c.pin_special_function, lvl_c};
				end
				default: begin
					// unmapped address reads zero
					rdata_d = 32'h0000_0000;
				end
			endcase
		end
	end

	// bus slave registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_readdata_o = rdata_q;

	// bank A storage, no special-function lane
	mgpio_bank #(
		.HAS_SF(1'b0)
	) u_bank_a (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_i(wr_sel[0]),
		.wdata_i(req.writedata),
		.be_i(req.byteenable),
		.ctrl_o(ctrl_a)
	);

	// bank C storage, with special-function lane
	mgpio_bank #(
		.HAS_SF(1'b1)
	) u_bank_c (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_i(wr_sel[1]),
		.wdata_i(req.writedata),
		.be_i(req.byteenable),
		.ctrl_o(ctrl_c)
	);

	// input synchroniser next state
	// pins are asynchronous; only the last stage feeds logic
	always_comb begin
		sync_a_d[0] = pin_a_i;
		sync_c_d[0] = pin_c_i;
		for (int s = 1; s < SYNC_STAGES; s++) begin
			sync_a_d[s] = sync_a_q[s-1];
			sync_c_d[s] = sync_c_q[s-1];
		end
	end

	// input synchroniser registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int s = 0; s < SYNC_STAGES; s++) begin
				sync_a_q[s] <= 8'h00;
				sync_c_q[s] <= 8'h00;
			end
		end else begin
			for (int s = 0; s < SYNC_STAGES; s++) begin
				sync_a_q[s] <= sync_a_d[s];
				sync_c_q[s] <= sync_c_d[s];
			end
		end
	end

	assign lvl_a = sync_a_q[SYNC_STAGES-1];
	assign lvl_c = sync_c_q[SYNC_STAGES-1];

	// serial outputs mapped to their bank A lines
	// reserved and incoming lines carry no source
	always_comb begin
		alt_out_a = 8'h00;
		alt_out_a[`MGPIO_A_TXD] = ser_txd_i;
		alt_out_a[`MGPIO_A_DTR] = ser_dtr_i;
		alt_out_a[`MGPIO_A_RTS] = ser_rts_i;
	end

	// per-line drive logic
	// a line is gpio when select and special bits are zero;
	// otherwise its alternate function owns the level and the
	// direction bit still gates the driver
	for (genvar i = 0; i < BANK_LINES; i++) begin : g_line
		assign gp_a[i] = ~ctrl_a.pin_function_select[i];
		assign gp_c[i] = ~ctrl_c.pin_function_select[i]
			& ~ctrl_c.pin_special_function[i];

		// bank A line
		always_comb begin
			// driver on only for direction one
			drv_a_d.oe[i] = ctrl_a.pin_direction[i];
			if (gp_a[i]) begin
				// gpio output takes the data bit
				drv_a_d.level[i] = ctrl_a.data[i];
			end else begin
				// function mode takes the serial unit
				drv_a_d.level[i] = alt_out_a[i];
			end
		end

		// bank C line
		always_comb begin
			drv_c_d.oe[i] = ctrl_c.pin_direction[i];
			if (gp_c[i]) begin
				drv_c_d.level[i] = ctrl_c.data[i];
			end else begin
				drv_c_d.level[i] = alt_c_i[i];
			end
		end
	end

	// pin drive registers
	// registered so pins never glitch on a partial lane write
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// all lines released, every line an input
			drv_a_q <= '0;
			drv_c_q <= '0;
		end else begin
			drv_a_q <= drv_a_d;
			drv_c_q <= drv_c_d;
		end
	end

	assign pin_a_o = drv_a_q.level;
	assign pin_a_oe_o = drv_a_q.oe;
	assign pin_c_o = drv_c_q.level;
	assign pin_c_oe_o = drv_c_q.oe;

	// incoming serial functions come straight from the
	// synchroniser, whatever mode the line is in, so the
	// serial unit must ignore them while a line is gpio
	assign ser_rxd_o = lvl_a[`MGPIO_A_RXD];
	assign ser_dsr_o = lvl_a[`MGPIO_A_DSR];
	assign ser_cts_o = lvl_a[`MGPIO_A_CTS];
	assign ser_dcd_o = lvl_a[`MGPIO_A_DCD];
	assign alt_c_o = lvl_c;

	// board status next state
	always_comb begin
		// indicator lit while its line drives low
		led_d = drv_c_q.oe[`MGPIO_C_LED] & ~drv_c_q.level[`MGPIO_C_LED];
		// spare line level for a soft-reset watcher
		spare_d = lvl_c[`MGPIO_C_SPARE];
	end

	// board status registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			led_q <= 1'b0;
			spare_q <= 1'b0;
		end else begin
			led_q <= led_d;
			spare_q <= spare_d;
		end
	end

	assign led_green_on_o = led_q;
	assign spare_line_level_o = spare_q;
endmodule

//--- pkg/mgpio_consts.svh
// offsets, field positions, reset values and timing counts of the gpio block
`ifndef MGPIO_CONSTS_SVH
`define MGPIO_CONSTS_SVH
// byte offsets of the two bank registers
`define MGPIO_BANK_A_OFS 4'h0
`define MGPIO_BANK_C_OFS 4'h4
// lsb of each 8-bit field inside a bank word
`define MGPIO_FSEL_LSB 24
`define MGPIO_DIR_LSB 16
`define MGPIO_SF_LSB 8
`define MGPIO_DATA_LSB 0
// lines per bank and register lanes
`define MGPIO_BANK_LINES 8
`define MGPIO_LANES 4
// reset value of a bank word
`define MGPIO_CTRL_RST 32'h0000_0000
// synchroniser depth for pin inputs
`define MGPIO_SYNC_STAGES 2
// bank A line positions of the serial functions
`define MGPIO_A_TXD 7
`define MGPIO_A_DTR 6
`define MGPIO_A_RTS 5
`define MGPIO_A_RXD 3
`define MGPIO_A_DSR 2
`define MGPIO_A_CTS 1
`define MGPIO_A_DCD 0
// bank C line positions
`define MGPIO_C_LED 6
`define MGPIO_C_SPARE 5
`endif

//--- pkg/mgpio_pkg.sv
// types shared by the gpio block files
package mgpio_pkg;
	// one bank word, field order matches the byte lanes
	typedef struct packed {
		logic [7:0] pin_function_select;
		logic [7:0] pin_direction;
		logic [7:0] pin_special_function;
		logic [7:0] data;
	} mgpio_ctrl_type;
	// drive of one 8-line bank
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] oe;
	} mgpio_drive_type;
	// one register bus request
	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} mgpio_req_type;
endpackage

//--- verification/mgpio_host_model.sv
// header-side host: drives or releases lines, pull-ups hold idle lines high
`timescale 1ns/1ps
module mgpio_host_model (
	// block drive
	input wire logic [7:0] dut_a_i,
	input wire logic [7:0] dut_a_oe_i,
	input wire logic [7:0] dut_c_i,
	input wire logic [7:0] dut_c_oe_i,
	// host drive and enables
	input wire logic [7:0] host_a_i,
	input wire logic [7:0] host_a_en_i,
	input wire logic [7:0] host_c_i,
	input wire logic [7:0] host_c_en_i,
	// resolved line levels
	output logic [7:0] line_a_o,
	output logic [7:0] line_c_o
);
	// block drive wins, then host; host may pull the spare line low
	always_comb begin
		line_a_o = (dut_a_oe_i & dut_a_i) | (~dut_a_oe_i & (~host_a_en_i | host_a_i));
		line_c_o = (dut_c_oe_i & dut_c_i) | (~dut_c_oe_i & (~host_c_en_i | host_c_i));
	end
endmodule

//--- verification/mgpio_props.sv
// concurrent checks on the gpio block ports
`timescale 1ns/1ps
module mgpio_props
	import mgpio_pkg::*;
#(
	parameter int SYNC_STAGES = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// register bus
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// pins and status
	input wire logic [7:0] pin_a_i,
	input wire logic [7:0] pin_a_o,
	input wire logic [7:0] pin_a_oe_o,
	input wire logic [7:0] pin_c_i,
	input wire logic [7:0] pin_c_o,
	input wire logic [7:0] pin_c_oe_o,
	input wire logic ser_rxd_o,
	input wire logic led_green_on_o,
	input wire logic spare_line_level_o
);
	// cycles since reset; sync flops still hold reset zeros early on
	logic [3:0] up_q;
	logic [3:0] up_d;
	logic ok;
	logic wr_ok;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// saturating count
	always_comb begin
		up_d = (up_q == 4'hf) ? up_q : up_q + 4'h1;
	end
	// count register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			up_q <= 4'h0;
		end else begin
			up_q <= up_d;
		end
	end
	assign ok = (up_q > 4'(SYNC_STAGES + 2));
	assign wr_ok = avs_write_i && !avs_waitrequest_o && (avs_byteenable_i == 4'hf);
	chk_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("no answer after one wait cycle");
	chk_a_gpio_drive: assert property (wr_ok && avs_address_i[3:2] == 2'b00
		&& avs_writedata_i[31:24] == 8'h00 |-> ##2 pin_a_oe_o == $past(avs_writedata_i[23:16], 2)
		&& pin_a_o == $past(avs_writedata_i[7:0], 2)) else $error("bank a drive wrong");
	chk_c_gpio_drive: assert property (wr_ok && avs_address_i[3:2] == 2'b01
		&& avs_writedata_i[31:8] == {8'h00, avs_writedata_i[23:16], 8'h00}
		|-> ##2 pin_c_oe_o == $past(avs_writedata_i[23:16], 2)
		&& pin_c_o == $past(avs_writedata_i[7:0], 2)) else $error("bank c drive wrong");
	chk_led_low_lit: assert property (ok |-> led_green_on_o ==
		$past(pin_c_oe_o[6] && !pin_c_o[6])) else $error("indicator state wrong");
	chk_rxd_follows: assert property (ok && $past(pin_a_i[3], 3) == pin_a_i[3]
		&& $past(pin_a_i[3], 2) == pin_a_i[3] && $past(pin_a_i[3]) == pin_a_i[3]
		|-> ser_rxd_o == pin_a_i[3]) else $error("receive line not followed");
	chk_spare_follows: assert property (ok && $past(pin_c_i[5], 3) == pin_c_i[5]
		&& $past(pin_c_i[5], 2) == pin_c_i[5] && $past(pin_c_i[5]) == pin_c_i[5]
		|-> spare_line_level_o == pin_c_i[5]) else $error("spare line not followed");
	chk_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
		&& avs_address_i[3] |-> avs_readdata_o == 32'h0000_0000) else $error("unmapped read");
	chk_a_no_special: assert property (avs_read_i && !avs_waitrequest_o
		&& avs_address_i[3:2] == 2'b00 |-> avs_readdata_o[15:8] == 8'h00)
		else $error("bank a special field set");
endmodule

//--- verification/test_module_gpio_pin_config.sv
// bench for the gpio block: bus tasks, host drive and checks
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("FAIL %s exp %0h got %0h", n, e, g); end end
module test_module_gpio_pin_config;
	import mgpio_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [3:0] avs_byteenable_i = 4'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [7:0] pin_a_i, pin_a_o, pin_a_oe_o, pin_c_i, pin_c_o, pin_c_oe_o, alt_c_o;
	logic ser_txd_i = 1'b0, ser_dtr_i = 1'b0, ser_rts_i = 1'b0;
	logic ser_rxd_o, ser_dsr_o, ser_cts_o, ser_dcd_o, led_green_on_o, spare_line_level_o;
	logic [7:0] alt_c_i = 8'h00, ha = 8'h00, ha_en = 8'h00, hc = 8'h00, hc_en = 8'h00;
	logic [31:0] rv;
	int n_fail = 0, n_tests = 0, cyc = 0;
	mgpio_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .pin_a_i(pin_a_i), .pin_a_o(pin_a_o),
		.pin_a_oe_o(pin_a_oe_o), .pin_c_i(pin_c_i), .pin_c_o(pin_c_o),
		.pin_c_oe_o(pin_c_oe_o), .ser_txd_i(ser_txd_i), .ser_dtr_i(ser_dtr_i),
		.ser_rts_i(ser_rts_i), .ser_rxd_o(ser_rxd_o), .ser_dsr_o(ser_dsr_o),
		.ser_cts_o(ser_cts_o), .ser_dcd_o(ser_dcd_o), .alt_c_i(alt_c_i), .alt_c_o(alt_c_o),
		.led_green_on_o(led_green_on_o), .spare_line_level_o(spare_line_level_o));
	mgpio_host_model host_u (.dut_a_i(pin_a_o), .dut_a_oe_i(pin_a_oe_o), .dut_c_i(pin_c_o),
		.dut_c_oe_i(pin_c_oe_o), .host_a_i(ha), .host_a_en_i(ha_en), .host_c_i(hc),
		.host_c_en_i(hc_en), .line_a_o(pin_a_i), .line_c_o(pin_c_i));
	always #2 clk_i = ~clk_i;
	// hang guard
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("counts: %0d compared, %0d failed", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// one access, held until waitrequest is low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] b);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= b;
		avs_write_i <= w;
		avs_read_i <= !w;
		// outputs read right after an edge still show their pre-edge values
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0) begin
			@(posedge clk_i);
		end
		rv = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		bus(1'b0, a, 32'h0000_0000, 4'hf);
	endtask
	// write, then let drive and two sync flops land
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
		bus(1'b1, a, d, b);
		repeat (6) @(posedge clk_i);
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		// all inputs, pull-ups visible
		rd(4'h0);
		`CHK("bank a", 32'h0000_00ff, rv)
		rd(4'h4);
		`CHK("bank c", 32'h0000_00ff, rv)
		`CHK("oe", 16'h0000, {pin_a_oe_o, pin_c_oe_o})
		$display("test reset ended");
		// read-modify-write, reserved a4 left as input
		rd(4'h0);
		wr(4'h0, {8'h00, 8'hef, rv[15:8], 8'ha5}, 4'hf);
		`CHK("a out", 16'hefa5, {pin_a_oe_o, pin_a_o})
		rd(4'h0);
		`CHK("a read", 32'h00ef_00b5, rv)
		`CHK("modem in", 4'b0101, {ser_rxd_o, ser_dsr_o, ser_cts_o, ser_dcd_o})
		wr(4'h0, 32'h0000_005a, 4'h1);
		`CHK("lane", 16'hef5a, {pin_a_oe_o, pin_a_o})
		$display("test output ended");
		// host drives bank a
		wr(4'h0, 32'h0000_0000, 4'hf);
		ha <= 8'h3c;
		ha_en <= 8'hff;
		rd(4'h0);
		rd(4'h0);
		`CHK("a in", 32'h0000_003c, rv)
		`CHK("modem in", 4'b1100, {ser_rxd_o, ser_dsr_o, ser_cts_o, ser_dcd_o})
		ha_en <= 8'h00;
		$display("test input ended");
		// serial functions on a7..a5
		ser_txd_i <= 1'b1;
		ser_rts_i <= 1'b1;
		wr(4'h0, 32'he0e0_0000, 4'hf);
		`CHK("serial out", 3'b101, pin_a_o[7:5])
		rd(4'h0);
		`CHK("serial read", 32'he0e0_00bf, rv)
		ser_txd_i <= 1'b0;
		ser_dtr_i <= 1'b1;
		ser_rts_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK("serial out", 3'b010, pin_a_o[7:5])
		$display("test serial ended");
		// indicator lit while driven low
		wr(4'h4, 32'h0060_0000, 4'hf);
		`CHK("led on", 1'b1, led_green_on_o)
		`CHK("spare", 1'b0, spare_line_level_o)
		rd(4'h4);
		`CHK("c read", 32'h0060_009f, rv)
		wr(4'h4, 32'h0040_0040, 4'hf);
		`CHK("led off", 1'b0, led_green_on_o)
		// host pulls the spare line low then lets go
		hc <= 8'h00;
		hc_en <= 8'h20;
		repeat (6) @(posedge clk_i);
		`CHK("spare low", 1'b0, spare_line_level_o)
		hc_en <= 8'h00;
		repeat (6) @(posedge clk_i);
		`CHK("spare high", 1'b1, spare_line_level_o)
		// special function routes the alternate source
		alt_c_i <= 8'h20;
		wr(4'h4, 32'h0060_2040, 4'hf);
		`CHK("alt out", 3'b111, {pin_c_o[6:5], alt_c_o[5]})
		alt_c_i <= 8'h00;
		repeat (6) @(posedge clk_i);
		`CHK("alt out", 3'b100, {pin_c_o[6:5], alt_c_o[5]})
		$display("test bank c ended");
		// unmapped places ignore writes and read zero
		wr(4'h8, 32'hffff_ffff, 4'hf);
		rd(4'h8);
		`CHK("unmapped", 32'h0000_0000, rv)
		rd(4'hc);
		`CHK("unmapped", 32'h0000_0000, rv)
		rd(4'h0);
		`CHK("a kept", 32'he0e0_005f, rv)
		$display("test unmapped ended");
		end_of_test();
	end
endmodule
bind mgpio_top mgpio_props #(.SYNC_STAGES(SYNC_STAGES)) u_props (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .pin_a_i(pin_a_i), .pin_a_o(pin_a_o),
	.pin_a_oe_o(pin_a_oe_o), .pin_c_i(pin_c_i), .pin_c_o(pin_c_o), .pin_c_oe_o(pin_c_oe_o),
	.ser_rxd_o(ser_rxd_o), .led_green_on_o(led_green_on_o),
	.spare_line_level_o(spare_line_level_o));
